//--- hdl/acd_top.sv
// Purpose: auxiliary converter calibration datapath with register port
// Assumes: raw samples arrive with step, selector and gain beside them
// Notes: results land at 10h..1Fh, one word per sequence step
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module acd_top
  import acd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic raw_valid,
  input wire logic [15:0] raw_data,
  input wire logic [3:0] raw_step,
  input wire logic [3:0] step_positive_input_select,
  input wire logic step_negative_is_last,
  input wire logic [1:0] aux_gain_setting,
  output logic bias_buffer_enable,
  output logic bias_to_last_input,
  output logic analog_inputs_connected,
  output logic negative_to_analog_ground,
  output logic config_error
);

  // ********************************
  // register decode
  // ********************************
  logic [15:0] offset_cal_value_r;
  logic [15:0] gain_cal_value_r;
  logic [15:0] config_r;
  logic [3:0] last_step_r;
  logic last_bypass_r;
  logic rd_mem_r;
  logic [15:0] rd_reg_r;

  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= ACD_OFS_RESULT_LO) && (a <= ACD_OFS_RESULT_HI);
  endfunction : is_result

  wire logic wr_offset = reg_wr && reg_addr == ACD_OFS_OFFSET_CAL;
  wire logic wr_gain = reg_wr && reg_addr == ACD_OFS_GAIN_CAL;
  wire logic wr_config = reg_wr && reg_addr == ACD_OFS_CONFIG;
  wire logic rd_result = reg_rd && is_result(reg_addr);
  wire logic [15:0] status_word = {9'h000, negative_to_analog_ground, config_error,
                                   last_bypass_r, last_step_r};
  wire logic [15:0] rd_reg_nxt = (reg_addr == ACD_OFS_OFFSET_CAL) ? offset_cal_value_r :
                                 (reg_addr == ACD_OFS_GAIN_CAL) ? gain_cal_value_r :
                                 (reg_addr == ACD_OFS_CONFIG) ? config_r :
                                 (reg_addr == ACD_OFS_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      offset_cal_value_r <= ACD_OFFSET_CAL_RST;
      gain_cal_value_r <= ACD_GAIN_CAL_RST;
      config_r <= ACD_CONFIG_RST;
    end else begin
      if (wr_offset) begin
        offset_cal_value_r <= reg_wdata;
      end
      if (wr_gain) begin
        gain_cal_value_r <= reg_wdata;
      end
      if (wr_config) begin
        config_r <= {15'h0000, reg_wdata[ACD_CFG_BIAS_EN_BIT]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_mem_r <= 1'b0;
      rd_reg_r <= 16'h0000;
    end else begin
      rd_mem_r <= rd_result;
      if (reg_rd) begin
        rd_reg_r <= rd_reg_nxt;
      end
    end
  end

  // ********************************
  // input selection control
  // ********************************
  wire logic pos_is_analog = step_positive_input_select <= ACD_SEL_LAST_INPUT;
  wire logic bypass = step_positive_input_select == ACD_SEL_TEMP_SENSOR;
  wire logic cfg_bad = pos_is_analog && step_negative_is_last
                       && step_positive_input_select == ACD_SEL_LAST_INPUT;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bias_buffer_enable <= 1'b0;
      bias_to_last_input <= 1'b0;
      analog_inputs_connected <= 1'b0;
      negative_to_analog_ground <= 1'b1;
      config_error <= 1'b0;
      last_step_r <= 4'h0;
      last_bypass_r <= 1'b0;
    end else begin
      bias_buffer_enable <= config_r[ACD_CFG_BIAS_EN_BIT];
      bias_to_last_input <= config_r[ACD_CFG_BIAS_EN_BIT];
      analog_inputs_connected <= pos_is_analog;
      negative_to_analog_ground <= !pos_is_analog || !step_negative_is_last;
      if (raw_valid) begin
        config_error <= cfg_bad;
        last_step_r <= raw_step;
        last_bypass_r <= bypass;
      end
    end
  end

  // ********************************
  // datapath and result storage
  // ********************************
  logic [3:0] step_d_r;
  wire logic corr_valid;
  wire logic [15:0] corr_data;
  wire logic [15:0] mem_rdata;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      step_d_r <= 4'h0;
    end else if (raw_valid) begin
      step_d_r <= raw_step;
    end
  end

  acd_correct u_correct (
    .mclk(mclk),
    .rst(rst),
    .in_valid(raw_valid),
    .in_raw(raw_data),
    .in_gain(aux_gain_setting),
    .in_bypass(bypass),
    .offset_cal_value(offset_cal_value_r),
    .gain_cal_value(gain_cal_value_r),
    .out_valid(corr_valid),
    .out_data(corr_data)
  );

  acd_result_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .wr_en(corr_valid),
    .wr_addr(step_d_r),
    .wr_data(corr_data),
    .rd_en(rd_result),
    .rd_addr(reg_addr[3:0]),
    .rd_data(mem_rdata)
  );

  assign reg_rdata = rd_mem_r ? mem_rdata : rd_reg_r;

endmodule : acd_top

//--- inc/acd_pkg.sv
// Purpose: shared constants of the auxiliary converter correction datapath
// Assumes: 16-bit register port, one clock
// Notes: all offsets are register indexes on the plain port
package acd_pkg;

  // ********************************
  // widths
  // ********************************
  localparam int ACD_DW = 16;
  localparam int ACD_AW = 8;
  localparam int ACD_STEPS = 16;
  localparam int ACD_FRAC = 16;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] ACD_OFS_OFFSET_CAL = 8'h01;
  localparam logic [7:0] ACD_OFS_GAIN_CAL = 8'h02;
  localparam logic [7:0] ACD_OFS_CONFIG = 8'h03;
  localparam logic [7:0] ACD_OFS_STATUS = 8'h04;
  localparam logic [7:0] ACD_OFS_RESULT_LO = 8'h10;
  localparam logic [7:0] ACD_OFS_RESULT_HI = 8'h1F;

  // ********************************
  // field positions and reset values
  // ********************************
  localparam int ACD_CFG_BIAS_EN_BIT = 0;
  localparam int ACD_ST_STEP_LSB = 0;
  localparam int ACD_ST_BYPASS_BIT = 4;
  localparam int ACD_ST_CFG_ERR_BIT = 5;
  localparam int ACD_ST_DISCONN_BIT = 6;
  localparam logic [15:0] ACD_OFFSET_CAL_RST = 16'h0000;
  localparam logic [15:0] ACD_GAIN_CAL_RST = 16'h0000;
  localparam logic [15:0] ACD_CONFIG_RST = 16'h0000;

  // ********************************
  // input selector and gain codes
  // ********************************
  localparam logic [3:0] ACD_SEL_LAST_INPUT = 4'h7;
  localparam logic [3:0] ACD_SEL_GROUND_SHORT = 4'h9;
  localparam logic [3:0] ACD_SEL_TEMP_SENSOR = 4'hA;
  localparam logic [1:0] ACD_GAIN_X1 = 2'h0;
  localparam logic [1:0] ACD_GAIN_X2 = 2'h1;
  localparam logic [1:0] ACD_GAIN_X4 = 2'h2;

  // ********************************
  // saturation codes
  // ********************************
  localparam logic [15:0] ACD_POS_FS = 16'h7FFF;
  localparam logic [15:0] ACD_NEG_FS = 16'h8000;

endpackage : acd_pkg

//--- hdl/acd_correct.sv
// Purpose: offset subtract, gain multiply, round and clip of one sample
// Assumes: raw sample is 16-bit two's complement
// Notes: one cycle from in_valid to out_valid
`timescale 1ns/1ps
module acd_correct
  import acd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [15:0] in_raw,
  input wire logic [1:0] in_gain,
  input wire logic in_bypass,
  input wire logic [15:0] offset_cal_value,
  input wire logic [15:0] gain_cal_value,
  output logic out_valid,
  output logic [15:0] out_data
);

  // ********************************
  // arithmetic
  // ********************************
  // offset step is two output codes at x4, one otherwise
  wire logic signed [17:0] off_scaled;
  wire logic signed [17:0] diff;
  wire logic signed [17:0] factor;
  wire logic signed [35:0] product;
  wire logic signed [35:0] rounded;
  wire logic signed [19:0] quot;
  wire logic [15:0] clipped;
  wire logic [15:0] result_nxt;

  assign off_scaled = (in_gain == ACD_GAIN_X4) ? {offset_cal_value[15], offset_cal_value, 1'b0}
                                               : {{2{offset_cal_value[15]}}, offset_cal_value};
  assign diff = {{2{in_raw[15]}}, in_raw} - off_scaled;
  assign factor = 18'sh1_0000 + {{2{gain_cal_value[15]}}, gain_cal_value};
  assign product = diff * factor;
  assign rounded = product + 36'sh0_0000_8000;
  assign quot = rounded[35:16];
  assign clipped = (quot > 20'sh0_7FFF) ? ACD_POS_FS :
                   (quot < -20'sh0_8000) ? ACD_NEG_FS : quot[15:0];
  assign result_nxt = in_bypass ? in_raw : clipped;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= 16'h0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_data <= result_nxt;
      end
    end
  end

endmodule : acd_correct

//--- hdl/acd_result_mem.sv
// Purpose: per-step result storage
// Assumes: one write and one read port
// Notes: read data registered, one cycle after rd_en
`timescale 1ns/1ps
module acd_result_mem
  import acd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] mem_r [ACD_STEPS];

  generate
    for (genvar i = 0; i < ACD_STEPS; i++) begin : g_word
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          mem_r[i] <= 16'h0000;
        end else if (wr_en && wr_addr == 4'(i)) begin
          mem_r[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule : acd_result_mem

//--- tb/acd_properties.sv
// Purpose: port checks of acd_top
// Assumes: one clock, async high reset
// Notes: bound after endmodule
`timescale 1ns/1ps
module acd_properties
  import acd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic raw_valid,
  input wire logic [15:0] raw_data,
  input wire logic [3:0] raw_step,
  input wire logic [3:0] step_positive_input_select,
  input wire logic step_negative_is_last,
  input wire logic [1:0] aux_gain_setting,
  input wire logic bias_buffer_enable,
  input wire logic bias_to_last_input,
  input wire logic analog_inputs_connected,
  input wire logic negative_to_analog_ground,
  input wire logic config_error
);
  wire logic [3:0] sel;
  assign sel = step_positive_input_select;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  cal_readback_a: assert property (reg_wr && reg_addr inside {8'h01, 8'h02} ##1
    reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("cal readback wrong");
  bias_cfg_a: assert property (reg_wr && reg_addr == ACD_OFS_CONFIG
    |-> ##2 bias_buffer_enable == $past(reg_wdata[0], 2)) else $error("bias enable wrong");
  bias_route_a: assert property (bias_to_last_input == bias_buffer_enable)
    else $error("bias route wrong");
  input_conn_a: assert property (raw_valid
    |=> analog_inputs_connected == ($past(sel) <= 4'h7)) else $error("connect wrong");
  neg_ground_a: assert property (raw_valid |=> negative_to_analog_ground ==
    ($past(sel) > 4'h7 || !$past(step_negative_is_last))) else $error("ground wrong");
  cfg_error_a: assert property (raw_valid |=> config_error ==
    ($past(sel) == 4'h7 && $past(step_negative_is_last))) else $error("cfg flag wrong");
  temp_pass_a: assert property (raw_valid && sel == ACD_SEL_TEMP_SENSOR ##1
    !raw_valid ##1 reg_rd && reg_addr == {4'h1, $past(raw_step, 2)}
    |=> reg_rdata == $past(raw_data, 3)) else $error("temp bypass wrong");
  unmapped_rd_a: assert property (reg_rd && reg_addr > ACD_OFS_RESULT_HI
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  cover property (raw_valid && sel == ACD_SEL_TEMP_SENSOR);
  cover property (config_error);
  cover property (reg_wr && reg_addr == ACD_OFS_CONFIG);
endmodule : acd_properties

bind acd_top acd_properties i_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .raw_valid(raw_valid), .raw_data(raw_data), .raw_step(raw_step),
  .step_positive_input_select(step_positive_input_select),
  .step_negative_is_last(step_negative_is_last), .aux_gain_setting(aux_gain_setting),
  .bias_buffer_enable(bias_buffer_enable), .bias_to_last_input(bias_to_last_input),
  .analog_inputs_connected(analog_inputs_connected),
  .negative_to_analog_ground(negative_to_analog_ground), .config_error(config_error));

//--- tb/acd_host.sv
// Purpose: host side of the register port
// Assumes: tasks are entered right after a rising edge
// Notes: a write leaves its strobe up until the next call
`timescale 1ns/1ps
module acd_host
  import acd_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    bus(1'b0, 1'b1, a, 16'h0000);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask : rd
  // volatile calibration reloaded after every reset
  task automatic reload();
    wr(ACD_OFS_OFFSET_CAL, 16'h0000);
    wr(ACD_OFS_GAIN_CAL, 16'h0000);
  endtask : reload
endmodule : acd_host

//--- tb/acd_top_test.sv
// Purpose: self-checking bench of acd_top
// Assumes: host model drives the register port
// Notes: corner samples, then random ones from a fixed seed
`timescale 1ns/1ps
module acd_top_test
  import acd_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic raw_valid = 1'b0;
  logic neg_last = 1'b0;
  logic [15:0] raw_data = 16'h0000;
  logic [3:0] raw_step = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [1:0] gain = 2'h0;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, bias_en, bias_last, conn, gnd, cfg_err;
  int seed = 52041;
  int n_mismatch = 0;
  int num_checks = 0;
  int k;
  initial begin
    forever #5 mclk = ~mclk;
  end
  acd_host i_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  acd_top i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
    .raw_data(raw_data), .raw_step(raw_step), .step_positive_input_select(sel),
    .step_negative_is_last(neg_last), .aux_gain_setting(gain), .bias_buffer_enable(bias_en),
    .bias_to_last_input(bias_last), .analog_inputs_connected(conn),
    .negative_to_analog_ground(gnd), .config_error(cfg_err));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] expect_out(logic [15:0] raw, logic [15:0] oc,
    logic [15:0] gc, logic [1:0] g, logic [3:0] s);
    longint d;
    longint p;
    if (s == ACD_SEL_TEMP_SENSOR) return raw;
    d = longint'($signed(raw)) - longint'($signed(oc)) * ((g == ACD_GAIN_X4) ? 2 : 1);
    p = (d * (65536 + longint'($signed(gc))) + 32768) >>> 16;
    if (p > 32767) return ACD_POS_FS;
    if (p < -32768) return ACD_NEG_FS;
    return p[15:0];
  endfunction : expect_out
  // status bits: negative grounded, config error, bypass
  function automatic logic [2:0] expect_st(logic [3:0] s, logic n);
    return {s > 4'h7 || !n, s == 4'h7 && n, s == ACD_SEL_TEMP_SENSOR};
  endfunction : expect_st
  task automatic run(input logic [15:0] raw, input logic [15:0] oc, input logic [15:0] gc,
    input logic [1:0] g, input logic [3:0] s);
    i_host.wr(ACD_OFS_OFFSET_CAL, oc);
    i_host.wr(ACD_OFS_GAIN_CAL, gc);
    i_host.rd(ACD_OFS_GAIN_CAL, v);
    chk("gain_cal", gc, v);
    raw_valid <= 1'b1;
    raw_data <= raw;
    sel <= s;
    gain <= g;
    neg_last <= 1'($random(seed));
    i_host.bus(1'b0, 1'b0, 8'h00, 16'h0000);
    raw_valid <= 1'b0;
    i_host.bus(1'b0, 1'b0, 8'h00, 16'h0000);
    i_host.rd({4'h1, raw_step}, v);
    chk("result", expect_out(raw, oc, gc, g, s), v);
    chk("sel_pins", {14'h0000, s <= 4'h7, s > 4'h7 || !neg_last}, {14'h0000, conn, gnd});
    i_host.rd(ACD_OFS_STATUS, v);
    chk("status", {9'h000, expect_st(s, neg_last), raw_step}, v);
    raw_step <= raw_step + 4'h1;
  endtask : run
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (k = 1; k <= 3; k++) begin
      i_host.rd(8'(k), v);
      chk("reset_value", 16'h0000, v);
    end
    i_host.reload();
    i_host.wr(ACD_OFS_CONFIG, 16'h0001);
    i_host.rd(ACD_OFS_CONFIG, v);
    chk("config", 16'h0001, v);
    chk("bias_enable", 16'h0003, {14'h0000, bias_last, bias_en});
    i_host.rd(8'h05, v);
    chk("unmapped", 16'h0000, v);
    i_host.rd(8'h20, v);
    chk("unmapped", 16'h0000, v);
    run(16'h1000, 16'h0010, 16'h0000, ACD_GAIN_X1, 4'h0);
    run(16'h1000, 16'hFFFF, 16'h0000, ACD_GAIN_X2, 4'h3);
    run(16'h1000, 16'h0010, 16'h0000, ACD_GAIN_X4, 4'h1);
    run(16'h4000, 16'h0000, 16'h7FFF, ACD_GAIN_X1, 4'h2);
    run(16'h4000, 16'h0000, 16'h8000, ACD_GAIN_X1, 4'h7);
    run(16'h7FFF, 16'hFFF0, 16'h7FFF, ACD_GAIN_X1, 4'h5);
    run(16'h8000, 16'h0010, 16'h7FFF, ACD_GAIN_X4, 4'h6);
    run(16'h1234, 16'h0010, 16'h7FFF, ACD_GAIN_X1, ACD_SEL_TEMP_SENSOR);
    // mid-run reset must drop the nonzero correction values
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (k = 1; k <= 2; k++) begin
      i_host.rd(8'(k), v);
      chk("cal_after_reset", 16'h0000, v);
    end
    chk("bias_after_reset", 16'h0000, {14'h0000, bias_last, bias_en});
    i_host.reload();
    run(16'h0003, 16'h0000, 16'h0000, ACD_GAIN_X2, ACD_SEL_GROUND_SHORT);
    repeat (48) begin
      k = $unsigned($random(seed)) % 10;
      run(16'($random(seed)), 16'($random(seed)), 16'($random(seed)),
        2'($unsigned($random(seed)) % 3), (k == 8) ? ACD_SEL_TEMP_SENSOR : 4'(k));
    end
    print_verdict();
  end
endmodule : acd_top_test
